// [core/dasr_readout.sv]
/*
  Digital side of a dual simultaneous-sampling 12-bit successive
  approximation converter with a two-output serial readout.
  Assumes the host drives chip select and serial clock far slower than
  clk_in (each sclk level held at least four clk_in cycles), and that
  the analog comparators answer within one clk_in after a DAC change.
*/
// Contract
// - Serial clock shifts data and alone steps the conversion.
// - Data outputs change only after a serial clock falling edge or a chip select rise.
// - Both results appear together, one on each output.
// - Frame: two zeros, then 12 result bits, MSB first.
// - Sixteen clocks give two trailing zeros after the result.
// - Further 16 clocks: each output carries the other result.
// - Chip select falling starts both conversions and frames transfer.
// - Range select sampled at chip select falling edge.
// - Input config select: low differential, high single-ended.
`timescale 1ns/10ps
`default_nettype none
module dasr_readout (
  input wire logic clk_in,                  // 20 MHz system clock
  input wire logic rst_in,                  // async reset, high
  input wire logic cs_n_in,                 // chip select pin, low
  input wire logic sclk_in,                 // serial clock pin
  input wire logic range_sel_in,            // input span select pin
  input wire logic input_config_select_in,  // 0 diff, 1 single-ended
  input wire logic [2:0] channel_pair_select_in, // channel pair pins
  input wire logic cmp_a_in,                // comparator A: in >= dac
  input wire logic cmp_b_in,                // comparator B: in >= dac
  output logic result_out_first,            // serial data, converter A
  output logic result_out_second,           // serial data, converter B
  output logic hold_out,                    // track/hold: 1 holds
  output logic range_sel_out,               // span for this conversion
  output logic input_config_select_out,     // filtered config select
  output logic [2:0] channel_pair_select_out, // latched channel pair
  output logic [11:0] dac_a_out,            // trial code, converter A
  output logic [11:0] dac_b_out             // trial code, converter B
);
  dasr_pkg::dasr_pins_t raw;
  dasr_pkg::dasr_pins_t pin;
  dasr_pkg::dasr_state_t q_ff;
  dasr_pkg::dasr_state_t nxt_q;
  logic cs_fall;
  logic sclk_fall;
  logic sclk_rise;

  assign raw = '{cs_n: cs_n_in, sclk: sclk_in, range_sel: range_sel_in,
                 input_config_select: input_config_select_in,
                 channel_pair_select: channel_pair_select_in,
                 cmp_a: cmp_a_in, cmp_b: cmp_b_in};

  dasr_pin_sync #(
    .W($bits(dasr_pkg::dasr_pins_t)),
    .RST_VAL(dasr_pkg::PINS_RST)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(raw),
    .level_out(pin)
  );

  // The position decode slices the counter by hand (low four bits for
  // the place in a frame, bit four for the chained half), so the
  // package layout is pinned here rather than trusted
  if (dasr_pkg::DATA_FIRST != dasr_pkg::LEAD_ZEROS)
  begin : g_chk_lead
    $error("dasr_readout: data must follow the leading zeros");
  end

  if (dasr_pkg::DATA_LAST - dasr_pkg::DATA_FIRST + 4'h1 !=
      dasr_pkg::RES_BITS)
  begin : g_chk_span
    $error("dasr_readout: data span must hold one result");
  end

  if (dasr_pkg::DATA_LAST + 4'h1 != dasr_pkg::FRAME_SHORT)
  begin : g_chk_short
    $error("dasr_readout: short frame must end on the last bit");
  end

  if (dasr_pkg::FRAME_BITS != (32'h1 << $bits(dasr_pkg::DATA_LAST)))
  begin : g_chk_frame
    $error("dasr_readout: frame must fill the low counter bits");
  end

  if (dasr_pkg::FRAME_SHORT >= dasr_pkg::FRAME_BITS)
  begin : g_chk_trail
    $error("dasr_readout: long frame must extend the short one");
  end

  if (dasr_pkg::CHAIN_END != dasr_pkg::FRAME_BITS + dasr_pkg::FRAME_BITS)
  begin : g_chk_chain
    $error("dasr_readout: chain must be two frames long");
  end

  if (dasr_pkg::CNT_W != $bits(dasr_pkg::CHAIN_END))
  begin : g_chk_cnt
    $error("dasr_readout: counter width must match the chain end");
  end

  if (dasr_pkg::RES_BITS != $bits(dasr_pkg::MASK_START))
  begin : g_chk_res
    $error("dasr_readout: result width must match the word fields");
  end

  if (dasr_pkg::MASK_START !=
      {1'b1, {(dasr_pkg::RES_BITS - 1){1'b0}}})
  begin : g_chk_mask
    $error("dasr_readout: first trial must be the top bit alone");
  end

  // Latency figures of the host contract assume this depth
  if (dasr_pkg::SYNC_STAGES != 32'h3)
  begin : g_chk_sync
    $error("dasr_readout: synchroniser bank is three stages deep");
  end

  if ($bits(dasr_pkg::PINS_RST) != $bits(dasr_pkg::dasr_pins_t))
  begin : g_chk_pins
    $error("dasr_readout: pin reset must cover every pin");
  end

  // Bit shown at frame position cnt; second half of a chain shows other
  function automatic logic frame_bit(
    input logic [5:0] cnt,
    input logic [11:0] own,
    input logic [11:0] other
  );
    logic [3:0] pos;
    logic [11:0] src;
    logic [3:0] idx;
    pos = cnt[3:0];
    src = cnt[4] ? other : own;
    idx = dasr_pkg::DATA_LAST - pos;
    frame_bit = 1'b0;
    if (cnt < dasr_pkg::CHAIN_END && pos >= dasr_pkg::DATA_FIRST &&
        pos <= dasr_pkg::DATA_LAST)
      frame_bit = src[idx];
  endfunction

  assign cs_fall = q_ff.cs_n & ~pin.cs_n;
  // serial clock edges only count inside a frame
  assign sclk_fall = q_ff.sclk & ~pin.sclk & ~pin.cs_n & ~q_ff.cs_n;
  assign sclk_rise = ~q_ff.sclk & pin.sclk & ~pin.cs_n & ~q_ff.cs_n;

  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.cs_n = pin.cs_n;
    nxt_q.sclk = pin.sclk;
    // config select follows its pin level
    nxt_q.input_config_select = pin.input_config_select;
    if (cs_fall)
    begin
      // sample both inputs and start both conversions
      nxt_q.hold = 1'b1;
      nxt_q.cnt = dasr_pkg::CNT_RST;
      nxt_q.sar_a = dasr_pkg::WORD_RST;
      nxt_q.sar_b = dasr_pkg::WORD_RST;
      nxt_q.mask = dasr_pkg::MASK_START;
      // span captured at chip select fall
      nxt_q.range_sel = pin.range_sel;
      // pair select taken as settled here
      nxt_q.channel_pair_select = pin.channel_pair_select;
    end
    else if (pin.cs_n)
    begin
      // Early chip select rise aborts the conversion and returns to track
      nxt_q.hold = 1'b0;
      nxt_q.cnt = dasr_pkg::CNT_RST;
      nxt_q.mask = dasr_pkg::WORD_RST;
    end
    else
    begin
      // one trial bit decided per serial clock rising edge
      if (sclk_rise && q_ff.mask != dasr_pkg::WORD_RST)
      begin
        if (pin.cmp_a)
          nxt_q.sar_a = q_ff.sar_a | q_ff.mask;
        if (pin.cmp_b)
          nxt_q.sar_b = q_ff.sar_b | q_ff.mask;
        nxt_q.mask = q_ff.mask >> 1;
        if (q_ff.mask == 12'h001)
          nxt_q.hold = 1'b0;
      end
      // frame position advances on falling edges, saturating
      if (sclk_fall && q_ff.cnt != dasr_pkg::CHAIN_END)
        nxt_q.cnt = q_ff.cnt + 6'h01;
    end
    // both outputs built from the same position
    // positions 14 and 15 fall outside the data span
    // positions 16 to 31 swap the sources
    nxt_q.dout_a = pin.cs_n ? 1'b0 :
                   frame_bit(nxt_q.cnt, nxt_q.sar_a, nxt_q.sar_b);
    nxt_q.dout_b = pin.cs_n ? 1'b0 :
                   frame_bit(nxt_q.cnt, nxt_q.sar_b, nxt_q.sar_a);
    nxt_q.dac_a = nxt_q.sar_a | nxt_q.mask;
    nxt_q.dac_b = nxt_q.sar_b | nxt_q.mask;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      q_ff <= '0;
      q_ff.cs_n <= 1'b1;
    end
    else
      q_ff <= nxt_q;
  end

  assign result_out_first = q_ff.dout_a;
  assign result_out_second = q_ff.dout_b;
  assign hold_out = q_ff.hold;
  assign range_sel_out = q_ff.range_sel;
  assign input_config_select_out = q_ff.input_config_select;
  assign channel_pair_select_out = q_ff.channel_pair_select;
  assign dac_a_out = q_ff.dac_a;
  assign dac_b_out = q_ff.dac_b;
endmodule
`default_nettype wire

// [core/dasr_pkg.sv]
/*
  Package for the dual converter serial readout block: frame layout,
  reset values and the packed carriers shared by the design files.
  Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
package dasr_pkg;
  // Frame layout in serial clock positions
  localparam int LEAD_ZEROS = 2;
  localparam int RES_BITS = 12;
  localparam int FRAME_SHORT = 14;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 6;
  localparam logic [5:0] CHAIN_END = 6'h20;
  localparam logic [3:0] DATA_FIRST = 4'h2;
  localparam logic [3:0] DATA_LAST = 4'hd;
  // Reset and start values, synchroniser depth
  localparam logic [11:0] MASK_START = 12'h800;
  localparam logic [11:0] WORD_RST = 12'h000;
  localparam logic [5:0] CNT_RST = 6'h00;
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic range_sel;
    logic input_config_select;
    logic [2:0] channel_pair_select;
    logic cmp_a;
    logic cmp_b;
  } dasr_pins_t;

  localparam logic [8:0] PINS_RST = 9'h100;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [CNT_W-1:0] cnt;
    logic [11:0] sar_a;
    logic [11:0] sar_b;
    logic [11:0] mask;
    logic hold;
    logic range_sel;
    logic input_config_select;
    logic [2:0] channel_pair_select;
    logic dout_a;
    logic dout_b;
    logic [11:0] dac_a;
    logic [11:0] dac_b;
  } dasr_state_t;
endpackage

// [core/dasr_pin_sync.sv]
/*
  Three-stage synchroniser bank for asynchronous pins. A bit's filtered
  level changes only once the second and third stages agree.
  Assumes clk_in is the only clock and rst_in is asynchronous high.
*/
`timescale 1ns/10ps
`default_nettype none
module dasr_pin_sync #(
  parameter int W = 9,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_in,          // system clock
  input wire logic rst_in,          // async reset, high
  input wire logic [W-1:0] pin_in,  // raw pin levels
  output logic [W-1:0] level_out    // filtered levels
);
  // Refuse an empty bank at elaboration
  if (W < 1)
  begin : g_chk_width
    $error("dasr_pin_sync: W must be at least 1");
  end

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic [2:0] stage_ff;
      logic level_ff;
      always_ff @(posedge clk_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          stage_ff <= {3{RST_VAL[i]}};
          level_ff <= RST_VAL[i];
        end
        else
        begin
          stage_ff <= {stage_ff[1:0], pin_in[i]};
          // Stage 0 feeds only stage 1; the filter looks at 1 and 2
          if (stage_ff[1] == stage_ff[2])
            level_ff <= stage_ff[2];
        end
      end
      assign level_out[i] = level_ff;
    end
  endgenerate
endmodule
`default_nettype wire

// [test/dasr_monitor.sv]
/* Port checker for dasr_readout; assumes serial phases of 6+ clk_in. */
`timescale 1ns/10ps
`default_nettype none
module dasr_monitor (
  input wire logic clk_in, // clock
  input wire logic rst_in, // reset
  input wire logic cs_n_in, // select
  input wire logic sclk_in, // serial clock
  input wire logic result_out_first, // data A
  input wire logic result_out_second, // data B
  input wire logic hold_out, // hold
  input wire logic [11:0] dac_a_out // trial A
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_idle_quiet:
  assert property (cs_n_in [*8] |-> !hold_out && !result_out_first
    && !result_out_second) else $error("idle");
  a_data_on_fall:
  assert property ($changed({result_out_first, result_out_second})
    |-> !sclk_in || cs_n_in) else $error("edge");
  a_lead_zeros:
  assert property ($fell(cs_n_in) |-> (!result_out_first
    && !result_out_second) [*8]) else $error("lead");
  a_hold_start:
  assert property ($fell(cs_n_in) |-> ##[3:7] hold_out) else $error("hold");
  a_hold_abort:
  assert property ($rose(cs_n_in) |-> ##[3:7] !hold_out) else $error("ab");
  a_dac_start:
  assert property ($rose(hold_out) |-> ##[0:1]
    dac_a_out == dasr_pkg::MASK_START) else $error("dac");
  // Two-cycle look back skips the load of the start code
  a_dac_still:
  assert property ($stable(sclk_in) [*8] ##0 (!cs_n_in && $past(hold_out, 2))
    |-> $stable(dac_a_out)) else $error("still");
  a_dac_step:
  assert property ($rose(sclk_in) && hold_out && !dac_a_out[0] |-> ##[2:8]
    $changed(dac_a_out)) else $error("step");
  c_start: cover property ($rose(hold_out));
  c_done: cover property ($fell(hold_out) && !cs_n_in);
  c_data: cover property ($rose(result_out_second));
endmodule
bind dasr_readout dasr_monitor u_mon (.*);
`default_nettype wire

// [test/dasr_analog_model.sv]
/* Comparator pair on the trial codes; assumes held bench input codes. */
`timescale 1ns/10ps
`default_nettype none
module dasr_analog_model (
  input wire logic [11:0] vin_a_in, // input A
  input wire logic [11:0] vin_b_in, // input B
  input wire logic [11:0] dac_a_in, // trial A
  input wire logic [11:0] dac_b_in, // trial B
  output logic cmp_a_out, // A at or above
  output logic cmp_b_out // B at or above
);
  assign cmp_a_out = vin_a_in >= dac_a_in;
  assign cmp_b_out = vin_b_in >= dac_b_in;
endmodule
`default_nettype wire

// [test/dasr_readout_test.sv]
/* Host frame bench for dasr_readout; assumes the comparator model. */
`timescale 1ns/10ps
`default_nettype none
module dasr_readout_test;
  logic clk_in = 0, rst_in = 1, cs_n_in = 1, sclk_in = 0, range_sel_in = 0;
  logic input_config_select_in = 0, cmp_a_in, cmp_b_in, result_out_first;
  logic result_out_second, hold_out, range_sel_out, input_config_select_out;
  logic [2:0] channel_pair_select_in = 3'h0, channel_pair_select_out;
  logic [11:0] va = 12'h000, vb = 12'h000, dac_a_out, dac_b_out;
  int mismatches = 0, samples_checked = 0, i, q, stop = 0;
  always #25 clk_in = ~clk_in;
  dasr_readout dut (.*);
  dasr_analog_model u_ana (.vin_a_in(va), .vin_b_in(vb), .dac_a_in(dac_a_out),
    .dac_b_in(dac_b_out), .cmp_a_out(cmp_a_in), .cmp_b_out(cmp_b_in));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic check(input logic [17:0] exp, got);
    samples_checked++;
    mismatches += int'(got !== exp);
    if (got !== exp)
      $display("MISMATCH %0t %h %h", $time, exp, got);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Phases of six cycles leave the data settled before each look
  task automatic frame(input int n, input logic [11:0] a, b,
    input logic r, input logic [2:0] c);
    if (stop != 0)
      return;
    {va, vb, range_sel_in, channel_pair_select_in} = {a, b, r, c};
    tick(2);
    cs_n_in = 0;
    for (i = 0; i < 20 && dac_a_out !== dasr_pkg::MASK_START; i++)
      tick(1);
    check({hold_out, range_sel_out, input_config_select_out,
      channel_pair_select_out, dac_a_out}, {1'b1, r, input_config_select_in,
      c, dasr_pkg::MASK_START});
    check(dac_b_out, dasr_pkg::MASK_START);
    if (i == 20)
    begin
      mismatches++;
      stop = 1;
      return;
    end
    // Pins move once the conversion has started; the latched copies stay
    {range_sel_in, channel_pair_select_in} = {~r, ~c};
    for (i = 1; i <= n; i++)
    begin
      sclk_in = 1;
      tick(6);
      sclk_in = 0;
      tick(6);
      q = i % 16;
      check({result_out_first, result_out_second, hold_out}, {(i > 31 ||
        q < 2 || q > 13) ? 2'b00 : i < 16 ? {a[13-q], b[13-q]} :
        {b[13-q], a[13-q]}, i < 12});
    end
    cs_n_in = 1;
    tick(10);
    check({hold_out, result_out_first, result_out_second, range_sel_out,
      channel_pair_select_out}, {3'h0, r, c});
  endtask
  initial
  begin
    tick(2);
    rst_in = 0;
    input_config_select_in = 1;
    frame(14, 12'ha5c, 12'h3a1, 1'b1, 3'h5);
    frame(6, 12'hfff, 12'h7ff, 1'b0, 3'h7);
    input_config_select_in = 0;
    frame(16, 12'hfff, 12'h000, 1'b0, 3'h2);
    frame(33, 12'h001, 12'h800, 1'b1, 3'h0);
    finish_test();
  end
endmodule
`default_nettype wire
